// ==== rtl/user_flash_sector_array.sv ====
/*
 * user flash sector array: 512 x 16 bit storage in two sectors, reached from
 * user logic through serial address and data registers with their own shift
 * clocks, plus program, erase and busy handshakes.
 * assumes all inputs but SYS_CLK and RST come from outside the SYS_CLK domain; each of those is passed
 * through two flip-flops and the shift clocks are edge-detected there.
 */
`default_nettype none

// Overview of operation
// - two sectors of 4096 bits each
// - erase one sector, other sector kept
// - 512 locations, 9-bit address, 000h-1FFh
// - each location holds a 16-bit word
// - address top bit selects the sector
// - no path into configuration flash
// - access unaffected by any security setting
// - data reg shifts MSB-first or loads word
// - address reg shifts or increments, wrapping
// - program rising edge writes word, busy
// - erase rising edge sets sector to FFFFh; busy ignores
module user_flash_sector_array #(
    parameter int PROG_CYCLES  = user_flash_pkg::PROG_CYCLES,  // program busy length
    parameter int ERASE_CYCLES = user_flash_pkg::ERASE_CYCLES  // erase busy length
) (
    input  wire logic SYS_CLK,    // system clock, 40 MHz
    input  wire logic RST,        // asynchronous reset, active high
    input  wire logic DATA_REG_SERIAL_IN,    // serial data into data register
    input  wire logic DATA_REG_SHIFT_CLOCK,  // data register clock
    input  wire logic DATA_REG_SHIFT_SELECT, // 1 shift, 0 load from array
    input  wire logic ADDR_REG_SERIAL_IN,    // serial data into address register
    input  wire logic ADDR_REG_SHIFT_CLOCK,  // address register clock
    input  wire logic ADDR_REG_SHIFT_SELECT, // 1 shift, 0 increment
    input  wire logic PROGRAM,    // rising edge programs one word
    input  wire logic ERASE,      // rising edge erases one sector
    output logic      DATA_REG_SERIAL_OUT,   // data register msb
    output logic      BUSY        // program or erase in progress
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (PROG_CYCLES < 1 || ERASE_CYCLES < 1) begin : g_chk
        $error("busy lengths must be at least one cycle");
    end

    localparam int AW = user_flash_pkg::ADDR_W;
    localparam int DW = user_flash_pkg::DATA_W;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] raw_in;     // raw pins
    logic [NSYNC-1:0] sync1_reg;  // first stage, read only by second
    logic [NSYNC-1:0] sync2_reg;  // second stage, usable
    logic [NSYNC-1:0] sync3_reg;  // delayed copy for edge detection

    assign raw_in = {ERASE, PROGRAM, ADDR_REG_SHIFT_SELECT, ADDR_REG_SHIFT_CLOCK,
                     ADDR_REG_SERIAL_IN, DATA_REG_SHIFT_SELECT, DATA_REG_SHIFT_CLOCK,
                     DATA_REG_SERIAL_IN};

    // two-flop synchroniser plus edge history
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    logic d_in, d_sel, a_in, a_sel;     // synchronised levels
    logic d_rise, a_rise, p_rise, e_rise; // rising edges
    assign d_in   = sync2_reg[0];
    assign d_rise = sync2_reg[1] & ~sync3_reg[1];
    assign d_sel  = sync2_reg[2];
    assign a_in   = sync2_reg[3];
    assign a_rise = sync2_reg[4] & ~sync3_reg[4];
    assign a_sel  = sync2_reg[5];
    assign p_rise = sync2_reg[6] & ~sync3_reg[6];
    assign e_rise = sync2_reg[7] & ~sync3_reg[7];

    // ************************************************************
    // storage array
    // ************************************************************
    // only this array is reachable; there is no port toward the
    // configuration image and no security input gating access
    logic [DW-1:0] mem_reg  [user_flash_pkg::WORDS]   // 512 words
                   = '{default: user_flash_pkg::ERASED_WORD};
    logic [DW-1:0] mem_next [user_flash_pkg::WORDS];  // next array contents

    // ************************************************************
    // registers and operation control
    // ************************************************************
    logic [AW-1:0]           addr_reg, addr_next;   // address register
    logic [DW-1:0]           data_reg, data_next;   // data register
    user_flash_pkg::op_state_t state_reg, state_next; // operation state
    logic [user_flash_pkg::CNT_W-1:0] cnt_reg, cnt_next; // busy counter
    logic                    sector_reg, sector_next; // sector latched for erase
    logic [AW-1:0]           paddr_reg, paddr_next;  // latched program address
    logic [DW-1:0]           pdata_reg, pdata_next;  // latched program word
    logic                    busy_reg, busy_next;    // busy output
    logic                    dout_reg, dout_next;    // serial out

    // next-state computation for registers, array and sequencer
    always_comb begin
        addr_next   = addr_reg;
        data_next   = data_reg;
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        sector_next = sector_reg;
        paddr_next  = paddr_reg;
        pdata_next  = pdata_reg;
        mem_next    = mem_reg;

        // address register: shift or increment with wrap
        if (a_rise) begin
            if (a_sel) begin
                addr_next = {addr_reg[AW-2:0], a_in};
            end else begin
                addr_next = (addr_reg == user_flash_pkg::ADDR_MAX) ?
                            user_flash_pkg::ADDR_RESET : addr_reg + 9'h001;
            end
        end

        // data register: shift toward msb or parallel load
        if (d_rise) begin
            if (d_sel) begin
                data_next = {data_reg[DW-2:0], d_in};
            end else begin
                data_next = mem_reg[addr_reg];
            end
        end

        unique case (state_reg)
            user_flash_pkg::ST_IDLE: begin
                // requests only taken while idle
                if (p_rise) begin
                    paddr_next = addr_reg;
                    pdata_next = data_reg;
                    cnt_next   = PROG_CYCLES - 1;
                    state_next = user_flash_pkg::ST_PROG;
                end else if (e_rise) begin
                    sector_next = addr_reg[user_flash_pkg::SECTOR_BIT];
                    cnt_next    = ERASE_CYCLES - 1;
                    state_next  = user_flash_pkg::ST_ERASE;
                end
            end
            user_flash_pkg::ST_PROG: begin
                if (cnt_reg == '0) begin
                    // flash programming only clears bits
                    mem_next[paddr_reg] = mem_reg[paddr_reg] & pdata_reg;
                    state_next = user_flash_pkg::ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            user_flash_pkg::ST_ERASE: begin
                if (cnt_reg == '0) begin
                    // only the chosen sector's 256 words are set
                    for (int i = 0; i < user_flash_pkg::SECTOR_WORDS; i++) begin
                        mem_next[{sector_reg, i[AW-2:0]}] = user_flash_pkg::ERASED_WORD;
                    end
                    state_next = user_flash_pkg::ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
        endcase

        busy_next = (state_next != user_flash_pkg::ST_IDLE);
        dout_next = data_next[DW-1];
    end

    // register stage
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            addr_reg   <= user_flash_pkg::ADDR_RESET;
            data_reg   <= user_flash_pkg::DATA_RESET;
            state_reg  <= user_flash_pkg::ST_IDLE;
            cnt_reg    <= '0;
            sector_reg <= 1'b0;
            paddr_reg  <= user_flash_pkg::ADDR_RESET;
            pdata_reg  <= user_flash_pkg::DATA_RESET;
            busy_reg   <= 1'b0;
            dout_reg   <= 1'b0;
        end else begin
            addr_reg   <= addr_next;
            data_reg   <= data_next;
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            sector_reg <= sector_next;
            paddr_reg  <= paddr_next;
            pdata_reg  <= pdata_next;
            busy_reg   <= busy_next;
            dout_reg   <= dout_next;
        end
    end

    // array is non-volatile: reset never touches it, and its power-on
    // contents (every word erased) come from its declaration, so that the
    // register stage below stays the only process that writes the array;
    // a fresh part reads all ones at every address
    // ************************************************************

    // array register stage
    always_ff @(posedge SYS_CLK) begin
        mem_reg <= mem_next;
    end

    assign DATA_REG_SERIAL_OUT = dout_reg;
    assign BUSY                = busy_reg;

endmodule

`default_nettype wire

// ==== rtl/user_flash_pkg.sv ====
/*
 * constants for the user flash sector array: geometry, reset values and
 * operation timing.
 * assumes a 40 MHz system clock; the package is referenced by scope only.
 */
`default_nettype none

package user_flash_pkg;

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int ADDR_W       = 9;                    // word address width
    localparam int DATA_W       = 16;                   // word width
    localparam int WORDS        = 512;                  // total locations
    localparam int SECTOR_BITS  = 4096;                 // bits per sector
    localparam int SECTOR_WORDS = SECTOR_BITS / DATA_W; // words per sector
    localparam int SECTOR_BIT   = ADDR_W - 1;           // address bit that picks the sector

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_RESET   = 9'h000;   // address register after reset
    localparam logic [DATA_W-1:0] DATA_RESET   = 16'h0000; // data register after reset
    localparam logic [DATA_W-1:0] ERASED_WORD  = 16'hFFFF; // value of an erased word
    localparam logic [ADDR_W-1:0] ADDR_MAX     = 9'h1FF;   // highest address

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ          = 40_000_000;       // system clock rate
    localparam int PROG_TIME_NS    = 75_000;           // word program time
    localparam int ERASE_TIME_MS   = 500;              // sector erase time
    localparam int PROG_CYCLES     = (PROG_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam longint ERASE_CYCLES_L = longint'(ERASE_TIME_MS) * (CLK_HZ / 1000);
    localparam int ERASE_CYCLES    = int'(ERASE_CYCLES_L);
    localparam int CNT_W           = 32;               // busy counter width

    // ************************************************************
    // operation states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_PROG  = 3'b010,
        ST_ERASE = 3'b100
    } op_state_t;

endpackage

`default_nettype wire

// ==== tb/user_flash_monitor.sv ====
/* checker for busy and serial-out timing at the flash array top ports.
   assumes it is bound to the top; link clocks hold each level >=3 cycles. */
`default_nettype none
module user_flash_monitor #(
    parameter int PROG_CYCLES  = 20, // program busy length
    parameter int ERASE_CYCLES = 50  // erase busy length
) (
    input wire logic SYS_CLK,              // system clock
    input wire logic RST,                  // async reset, active high
    input wire logic DATA_REG_SHIFT_CLOCK, // data register clock pin
    input wire logic PROGRAM,              // program request pin
    input wire logic ERASE,                // erase request pin
    input wire logic DATA_REG_SERIAL_OUT,  // serial out
    input wire logic BUSY                  // busy flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt_reg, cnt_next;             // busy cycles so far
    logic [3:0]  dage_reg, dage_next;           // cycles since data clock rise
    logic [3:0]  rage_reg, rage_next;           // cycles since request rise
    logic        lastp_reg, lastp_next;         // last accepted request was program
    logic        dclk_reg, prog_reg, erase_reg; // delayed pins for edge finding
    // helper counters, next values
    always_comb begin
        cnt_next = BUSY ? cnt_reg + 32'h1 : 32'h0;
        dage_next = (dage_reg == 4'hF) ? dage_reg : dage_reg + 4'h1;
        if (DATA_REG_SHIFT_CLOCK && !dclk_reg) dage_next = 4'h0;
        rage_next = (rage_reg == 4'hF) ? rage_reg : rage_reg + 4'h1;
        if ((PROGRAM && !prog_reg) || (ERASE && !erase_reg)) rage_next = 4'h0;
        lastp_next = lastp_reg;
        if (!BUSY && PROGRAM && !prog_reg) lastp_next = 1'b1;
        else if (!BUSY && ERASE && !erase_reg) lastp_next = 1'b0;
    end
    // helper registers only
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            {cnt_reg, dage_reg, rage_reg} <= {32'h0, 4'hF, 4'hF};
            {lastp_reg, dclk_reg, prog_reg, erase_reg} <= 4'h0;
        end else begin
            {cnt_reg, dage_reg, rage_reg} <= {cnt_next, dage_next, rage_next};
            {lastp_reg, dclk_reg, prog_reg, erase_reg} <=
                {lastp_next, DATA_REG_SHIFT_CLOCK, PROGRAM, ERASE};
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    property p_prog_busy; $rose(PROGRAM) && !BUSY |-> ##[2:7] BUSY; endproperty
    a_prog_busy: assert property (p_prog_busy) else $error("busy late after program");
    property p_erase_busy; $rose(ERASE) && !BUSY |-> ##[2:7] BUSY; endproperty
    a_erase_busy: assert property (p_erase_busy) else $error("busy late after erase");
    property p_busy_cause; $rose(BUSY) |-> rage_reg inside {[4'h1:4'h7]}; endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without request");
    property p_prog_len; $fell(BUSY) && lastp_reg |-> cnt_reg == 32'(PROG_CYCLES); endproperty
    a_prog_len: assert property (p_prog_len) else $error("program busy length");
    property p_erase_len; $fell(BUSY) && !lastp_reg |-> cnt_reg == 32'(ERASE_CYCLES); endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase busy length");
    property p_busy_min; $rose(BUSY) |-> BUSY [*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    property p_busy_max; BUSY |-> cnt_reg < 32'(ERASE_CYCLES); endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_out_cause; $changed(DATA_REG_SERIAL_OUT) |-> dage_reg inside {[4'h1:4'h7]};
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("serial out moved alone");
    c_prog: cover property ($fell(BUSY) && lastp_reg);
    c_erase: cover property ($fell(BUSY) && !lastp_reg);
    c_out: cover property ($changed(DATA_REG_SERIAL_OUT));
endmodule
`default_nettype wire

// ==== tb/user_logic_bridge_model.sv ====
/* model of the user bridging logic that drives the serial flash pins.
   assumes the bench calls its tasks just after a falling clock edge. */
`default_nettype none
module user_logic_bridge_model (
    input  wire logic SYS_CLK, // system clock
    input  wire logic BUSY,    // busy from array
    input  wire logic s_out,   // serial out from array
    output var logic  d_in,    // data serial in
    output var logic  d_clk,   // data clock
    output var logic  d_sel,   // data shift select
    output var logic  a_in,    // address serial in
    output var logic  a_clk,   // address clock
    output var logic  a_sel,   // address shift select
    output var logic  prog,    // program request
    output var logic  erase    // erase request
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {d_in, d_clk, d_sel, a_in, a_clk, a_sel, prog, erase} = 8'h00;
    // half link period: 100 ns
    task automatic half; repeat (4) @(negedge SYS_CLK); endtask
    // one data clock; serial line shows the inverse once the rise is taken,
    // so a late sample of the bit picks up the wrong value
    task automatic pulse_d(input logic sel, input logic din);
        d_sel = sel;
        d_in  = din;
        half();
        d_clk = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        d_in = ~din;
        repeat (2) @(negedge SYS_CLK);
        d_clk = 1'b0;
    endtask
    // one address clock; same late-sample trap on the serial line
    task automatic pulse_a(input logic sel, input logic ain);
        a_sel = sel;
        a_in  = ain;
        half();
        a_clk = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        a_in = ~ain;
        repeat (2) @(negedge SYS_CLK);
        a_clk = 1'b0;
    endtask
    task automatic set_addr(input logic [8:0] a);
        for (int i = 8; i >= 0; i--) pulse_a(1'b1, a[i]);
    endtask
    task automatic write(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) pulse_d(1'b1, w[i]);
    endtask
    // load word then shift it out msb first
    task automatic read(output logic [15:0] w);
        pulse_d(1'b0, 1'($urandom));
        for (int i = 15; i >= 0; i--) begin
            half(); w[i] = s_out;
            if (i > 0) pulse_d(1'b1, 1'($urandom));
        end
    endtask
    // request and wait; no register clock while busy
    task automatic req(input logic ers, input logic twice, output logic ok);
        int n;
        n = 0;
        if (ers) erase = 1'b1; else prog = 1'b1;
        while (!BUSY && n < 12) begin @(negedge SYS_CLK); n++; end
        if (twice) begin prog = 1'b0; half(); prog = 1'b1; end
        while (BUSY && n < 300) begin @(negedge SYS_CLK); n++; end
        ok = (n < 300);
        prog = 1'b0; erase = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/user_flash_sector_array_tb.sv ====
/* self-checking bench for the flash array with a reference word store.
   assumes short busy counts of 20 and 50 cycles. */
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module user_flash_sector_array_tb;
    timeunit 1ns; timeprecision 1ps;
    logic SYS_CLK = 1'b0, RST = 1'b1;       // clock and reset
    wire  d_in, d_clk, d_sel, a_in, a_clk, a_sel, prog, erase, s_out, busy; // pins
    int   error_cnt = 0, cmp_count = 0;     // tallies
    logic [15:0] mem [512];                 // reference contents
    logic ok;                               // request finished in time
    always #12.5 SYS_CLK = ~SYS_CLK;
    user_flash_sector_array #(.PROG_CYCLES(20), .ERASE_CYCLES(50)) i_user_flash_sector_array (
        .SYS_CLK(SYS_CLK), .RST(RST), .DATA_REG_SERIAL_IN(d_in), .DATA_REG_SHIFT_CLOCK(d_clk),
        .DATA_REG_SHIFT_SELECT(d_sel), .ADDR_REG_SERIAL_IN(a_in), .ADDR_REG_SHIFT_CLOCK(a_clk),
        .ADDR_REG_SHIFT_SELECT(a_sel), .PROGRAM(prog), .ERASE(erase),
        .DATA_REG_SERIAL_OUT(s_out), .BUSY(busy));
    user_logic_bridge_model i_user_logic_bridge_model (.SYS_CLK(SYS_CLK), .BUSY(busy),
        .s_out(s_out), .d_in(d_in), .d_clk(d_clk), .d_sel(d_sel), .a_in(a_in), .a_clk(a_clk),
        .a_sel(a_sel), .prog(prog), .erase(erase));
    // read one word, setting the address first if asked
    task automatic rd(input logic [8:0] a, input logic set);
        logic [15:0] w;
        if (set) i_user_logic_bridge_model.set_addr(a);
        i_user_logic_bridge_model.read(w);
        `CHK(w, mem[a])
    endtask
    // program a word; flash only clears bits
    task automatic pg(input logic [8:0] a, input logic [15:0] d, input logic twice);
        i_user_logic_bridge_model.set_addr(a);
        i_user_logic_bridge_model.write(d);
        i_user_logic_bridge_model.req(1'b0, twice, ok);
        `CHK(ok, 1'b1)
        mem[a] = mem[a] & d;
        repeat (8) @(negedge SYS_CLK);
        `CHK(busy, 1'b0)
    endtask
    task automatic test_done;
        $display("compares=%0d errors=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard
    initial begin #2ms; error_cnt++; test_done(); end
    initial begin
        logic [8:0] a;
        for (int k = 0; k < 512; k++) mem[k] = 16'hFFFF;
        void'($urandom(80));
        repeat (20) @(negedge SYS_CLK);
        RST = 1'b0;
        `CHK(busy, 1'b0)
        rd(9'h000, 1'b1);
        for (int i = 0; i < 8; i++) begin
            a = (i < 4) ? 9'(i * 9'h0FF + i / 2) : 9'($urandom);
            pg(a, 16'($urandom), i[0]);
            rd(a, 1'b1);
        end
        pg(9'h0FF, 16'($urandom), 1'b0);
        rd(9'h0FF, 1'b1);
        for (int s = 0; s < 2; s++) begin
            rd({s[0], 8'hFF}, 1'b1);
            i_user_logic_bridge_model.pulse_a(1'b0, 1'($urandom));
            rd({~s[0], 8'h00}, 1'b0);
        end
        for (int s = 1; s >= 0; s--) begin
            i_user_logic_bridge_model.set_addr({s[0], 8'($urandom)});
            i_user_logic_bridge_model.req(1'b1, 1'b0, ok);
            `CHK(ok, 1'b1)
            for (int k = 0; k < 256; k++) mem[{s[0], 8'(k)}] = 16'hFFFF;
            rd({s[0], 8'h00}, 1'b1);
            rd(9'h0FF, 1'b1);
            rd(9'h1FF, 1'b1);
        end
        test_done();
    end
endmodule
bind user_flash_sector_array user_flash_monitor #(.PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) i_user_flash_monitor (.SYS_CLK(SYS_CLK), .RST(RST),
    .DATA_REG_SHIFT_CLOCK(DATA_REG_SHIFT_CLOCK), .PROGRAM(PROGRAM), .ERASE(ERASE),
    .DATA_REG_SERIAL_OUT(DATA_REG_SERIAL_OUT), .BUSY(BUSY));
`default_nettype wire
